// *** hw/poc_cfg.svh ***
`ifndef POC_CFG_SVH
`define POC_CFG_SVH

`define POC_OFF_PORT_VALUE 4'h0
`define POC_OFF_PORT_DIR 4'h1
`define POC_OFF_ROUTE 4'h2
`define POC_OFF_OC_ENABLE 4'h3
`define POC_OFF_REDUCED_DRIVE 4'h4
`define POC_OFF_OC_FLAG 4'h5
`define POC_OFF_OC_IRQ_EN 4'h6
`define POC_OFF_HV_ANALOG 4'h7
`define POC_OFF_HV_DIRECT 4'h8
`define POC_OFF_HV_PULL 4'h9
`define POC_OFF_HV_OVERRIDE 4'hA
`define POC_OFF_HV_DIG_EN 4'hB
`define POC_OFF_HV_LEVEL 4'hC
`define POC_OFF_EVT_STATUS 4'hD
`define POC_OFF_EVT_MASK 4'hE

`define POC_ROUTE_BIT 7
`define POC_PIN_ZERO 0
`define POC_PIN_TWO 2
`define POC_EVT_TRIP_ZERO 0
`define POC_EVT_TRIP_TWO 1
`define POC_EVT_HV_CHANGE 2

`define POC_RST_BYTE 8'h00
`define POC_RST_PORT 3'h0
`define POC_RST_OC 2'h0
`define POC_RST_HV 6'h00
`define POC_RST_EVT 3'h0
`endif

// *** hw/poc_pkg.sv ***
package poc_pkg;
	typedef enum logic [1:0] {
		POC_OC_OFF = 2'b00,
		POC_OC_ARMED = 2'b01,
		POC_OC_TRIPPED = 2'b10
	} poc_oc_state_type;
endpackage : poc_pkg

// *** hw/poc_oc_channel.sv ***
`timescale 1ns/1ps
module poc_oc_channel (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic monitorEnable,
	input wire logic stopMode,
	input wire logic fullDrive,
	input wire logic driveHigh,
	input wire logic overDetect,
	input wire logic flagClear,
	output logic monitorPower,
	output logic flag,
	output logic tripPulse,
	output logic forceLow
);
	poc_pkg::poc_oc_state_type state_ff;
	poc_pkg::poc_oc_state_type nxt_state;

	always_comb
	begin
		monitorPower = monitorEnable && !stopMode;
		tripPulse = (state_ff == poc_pkg::POC_OC_ARMED) && monitorPower && fullDrive
			&& driveHigh && overDetect;
		nxt_state = state_ff;
		case (state_ff)
			poc_pkg::POC_OC_OFF:
				if (monitorPower)
					nxt_state = poc_pkg::POC_OC_ARMED;
			poc_pkg::POC_OC_ARMED:
				if (tripPulse)
					nxt_state = poc_pkg::POC_OC_TRIPPED;
				else if (!monitorPower)
					nxt_state = poc_pkg::POC_OC_OFF;
			poc_pkg::POC_OC_TRIPPED:
				// The flag outlives the monitor power so a trip is never forgotten.
				if (flagClear)
					nxt_state = monitorPower ? poc_pkg::POC_OC_ARMED : poc_pkg::POC_OC_OFF;
			default:
				nxt_state = poc_pkg::POC_OC_OFF;
		endcase
		flag = (state_ff == poc_pkg::POC_OC_TRIPPED);
		// The trip term kills the driver in the detecting cycle, before the flag lands.
		forceLow = flag || tripPulse;
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			state_ff <= poc_pkg::POC_OC_OFF;
		else
			state_ff <= nxt_state;
	end
endmodule : poc_oc_channel

// *** hw/poc_hv_input.sv ***
`timescale 1ns/1ps
`include "poc_cfg.svh"
module poc_hv_input (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic stopMode,
	input wire logic [5:0] analogEnable,
	input wire logic [5:0] directMode,
	input wire logic [5:0] pullSelect,
	input wire logic [5:0] bufferOverride,
	input wire logic [5:0] digitalEnable,
	input wire logic [5:0] padLevel,
	output logic [5:0] bufferEnable,
	output logic [5:0] pullUpEn,
	output logic [5:0] pullDownEn,
	output logic [5:0] inputLevel,
	output logic levelChange
);
	logic [5:0] level_ff;
	logic [5:0] nxt_level;

	always_comb
	begin
		// Outside stop mode, analog mode shuts the buffer off against shoot-through unless overridden with direct mode off.
		if (stopMode)
			bufferEnable = digitalEnable;
		else
			bufferEnable = (analogEnable & bufferOverride & ~directMode)
				| (~analogEnable & digitalEnable);
		pullUpEn = pullSelect;
		pullDownEn = ~pullSelect;
		nxt_level = padLevel & bufferEnable;
		levelChange = |(nxt_level ^ level_ff);
		inputLevel = level_ff;
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			level_ff <= `POC_RST_HV;
		else
			level_ff <= nxt_level;
	end
endmodule : poc_hv_input

// *** hw/poc_port_guard.sv ***
// Design decisions made here: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "poc_cfg.svh"
module poc_port_guard (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [3:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrStb,
	input wire logic regRdStb,
	output logic [7:0] regRdData,
	input wire logic stopMode,
	input wire logic [2:0] portPinIn,
	output logic [2:0] portPinOut,
	output logic [2:0] portPinOe,
	output logic [2:0] fullDrive,
	input wire logic [1:0] overcurrentDetect,
	output logic [1:0] overcurrentMonitorPower,
	input wire logic timerCh1Pin,
	input wire logic serialZeroReceive,
	output logic timerOneCapture1In,
	input wire logic [5:0] hvPadLevel,
	output logic [5:0] hvBufferEnable,
	output logic [5:0] hvPullUpEn,
	output logic [5:0] hvPullDownEn,
	output logic irq
);
	// Channel vectors use index 0 for pin zero and index 1 for pin two.
	function automatic logic [7:0] poc_pack_oc(input logic [1:0] v);
		logic [7:0] p;
		p = `POC_RST_BYTE;
		p[`POC_PIN_ZERO] = v[0];
		p[`POC_PIN_TWO] = v[1];
		return p;
	endfunction : poc_pack_oc

	function automatic logic [1:0] poc_unpack_oc(input logic [7:0] b);
		return {b[`POC_PIN_TWO], b[`POC_PIN_ZERO]};
	endfunction : poc_unpack_oc

	logic [2:0] portOutputValue_ff, nxt_portOutputValue;
	logic [2:0] portDirection_ff, nxt_portDirection;
	logic captureToSerialRxRoute_ff, nxt_captureToSerialRxRoute;
	logic [1:0] overcurrentMonitorEnable_ff, nxt_overcurrentMonitorEnable;
	logic [2:0] reducedDrive_ff, nxt_reducedDrive;
	logic [1:0] overcurrentIrqEnable_ff, nxt_overcurrentIrqEnable;
	logic [5:0] hvAnalogEnable_ff, nxt_hvAnalogEnable;
	logic [5:0] hvDirectMode_ff, nxt_hvDirectMode;
	logic [5:0] hvPullSelect_ff, nxt_hvPullSelect;
	logic [5:0] hvBufferOverride_ff, nxt_hvBufferOverride;
	logic [5:0] hvDigitalEnable_ff, nxt_hvDigitalEnable;
	logic [2:0] evtStatus_ff, nxt_evtStatus;
	logic [2:0] evtMask_ff, nxt_evtMask;
	logic [7:0] regRdData_ff, nxt_regRdData;
	logic capture_ff, nxt_capture;
	logic irq_ff, nxt_irq;

	logic [1:0] ocFlag;
	logic [1:0] ocTrip;
	logic [1:0] ocForceLow;
	logic [1:0] ocClear;
	logic [1:0] ocDriveHigh;
	logic [1:0] ocFullDrive;
	logic [5:0] hvInputLevel;
	logic hvLevelChange;
	logic [2:0] events;

	always_comb
	begin
		ocClear = (regWrStb && regAddr == `POC_OFF_OC_FLAG)
			? poc_unpack_oc(regWrData) : 2'b00;
		ocDriveHigh = poc_unpack_oc({5'h00, portDirection_ff & portOutputValue_ff});
		ocFullDrive = poc_unpack_oc({5'h00, fullDrive});
	end

	poc_oc_channel u_ocZero (
		.clk(clk),
		.sys_rst(sys_rst),
		.monitorEnable(overcurrentMonitorEnable_ff[0]),
		.stopMode(stopMode),
		.fullDrive(ocFullDrive[0]),
		.driveHigh(ocDriveHigh[0]),
		.overDetect(overcurrentDetect[0]),
		.flagClear(ocClear[0]),
		.monitorPower(overcurrentMonitorPower[0]),
		.flag(ocFlag[0]),
		.tripPulse(ocTrip[0]),
		.forceLow(ocForceLow[0])
	);

	poc_oc_channel u_ocTwo (
		.clk(clk),
		.sys_rst(sys_rst),
		.monitorEnable(overcurrentMonitorEnable_ff[1]),
		.stopMode(stopMode),
		.fullDrive(ocFullDrive[1]),
		.driveHigh(ocDriveHigh[1]),
		.overDetect(overcurrentDetect[1]),
		.flagClear(ocClear[1]),
		.monitorPower(overcurrentMonitorPower[1]),
		.flag(ocFlag[1]),
		.tripPulse(ocTrip[1]),
		.forceLow(ocForceLow[1])
	);

	poc_hv_input u_hv (
		.clk(clk),
		.sys_rst(sys_rst),
		.stopMode(stopMode),
		.analogEnable(hvAnalogEnable_ff),
		.directMode(hvDirectMode_ff),
		.pullSelect(hvPullSelect_ff),
		.bufferOverride(hvBufferOverride_ff),
		.digitalEnable(hvDigitalEnable_ff),
		.padLevel(hvPadLevel),
		.bufferEnable(hvBufferEnable),
		.pullUpEn(hvPullUpEn),
		.pullDownEn(hvPullDownEn),
		.inputLevel(hvInputLevel),
		.levelChange(hvLevelChange)
	);

	always_comb
	begin
		nxt_portOutputValue = portOutputValue_ff;
		nxt_portDirection = portDirection_ff;
		nxt_captureToSerialRxRoute = captureToSerialRxRoute_ff;
		nxt_overcurrentMonitorEnable = overcurrentMonitorEnable_ff;
		nxt_reducedDrive = reducedDrive_ff;
		nxt_overcurrentIrqEnable = overcurrentIrqEnable_ff;
		nxt_hvAnalogEnable = hvAnalogEnable_ff;
		nxt_hvDirectMode = hvDirectMode_ff;
		nxt_hvPullSelect = hvPullSelect_ff;
		nxt_hvBufferOverride = hvBufferOverride_ff;
		nxt_hvDigitalEnable = hvDigitalEnable_ff;
		nxt_evtMask = evtMask_ff;
		if (regWrStb)
		begin
			case (regAddr)
				`POC_OFF_PORT_VALUE: nxt_portOutputValue = regWrData[2:0];
				`POC_OFF_PORT_DIR: nxt_portDirection = regWrData[2:0];
				`POC_OFF_ROUTE: nxt_captureToSerialRxRoute = regWrData[`POC_ROUTE_BIT];
				`POC_OFF_OC_ENABLE: nxt_overcurrentMonitorEnable = poc_unpack_oc(regWrData);
				`POC_OFF_REDUCED_DRIVE: nxt_reducedDrive = regWrData[2:0];
				`POC_OFF_OC_IRQ_EN: nxt_overcurrentIrqEnable = poc_unpack_oc(regWrData);
				`POC_OFF_HV_ANALOG: nxt_hvAnalogEnable = regWrData[5:0];
				`POC_OFF_HV_DIRECT: nxt_hvDirectMode = regWrData[5:0];
				`POC_OFF_HV_PULL: nxt_hvPullSelect = regWrData[5:0];
				`POC_OFF_HV_OVERRIDE: nxt_hvBufferOverride = regWrData[5:0];
				`POC_OFF_HV_DIG_EN: nxt_hvDigitalEnable = regWrData[5:0];
				`POC_OFF_EVT_MASK: nxt_evtMask = regWrData[2:0];
				default: nxt_evtMask = evtMask_ff;
			endcase
		end
		events = {hvLevelChange, ocTrip[1], ocTrip[0]};
		// A read clears the status, but an event in the same cycle survives it.
		nxt_evtStatus = ((regRdStb && regAddr == `POC_OFF_EVT_STATUS)
			? `POC_RST_EVT : evtStatus_ff) | events;
		nxt_regRdData = `POC_RST_BYTE;
		if (regRdStb)
		begin
			case (regAddr)
				`POC_OFF_PORT_VALUE: nxt_regRdData = {5'h00, portOutputValue_ff};
				`POC_OFF_PORT_DIR: nxt_regRdData = {5'h00, portDirection_ff};
				`POC_OFF_ROUTE: nxt_regRdData = {captureToSerialRxRoute_ff, 7'h00};
				`POC_OFF_OC_ENABLE: nxt_regRdData = poc_pack_oc(overcurrentMonitorEnable_ff);
				`POC_OFF_REDUCED_DRIVE: nxt_regRdData = {5'h00, reducedDrive_ff};
				`POC_OFF_OC_FLAG: nxt_regRdData = poc_pack_oc(ocFlag);
				`POC_OFF_OC_IRQ_EN: nxt_regRdData = poc_pack_oc(overcurrentIrqEnable_ff);
				`POC_OFF_HV_ANALOG: nxt_regRdData = {2'h0, hvAnalogEnable_ff};
				`POC_OFF_HV_DIRECT: nxt_regRdData = {2'h0, hvDirectMode_ff};
				`POC_OFF_HV_PULL: nxt_regRdData = {2'h0, hvPullSelect_ff};
				`POC_OFF_HV_OVERRIDE: nxt_regRdData = {2'h0, hvBufferOverride_ff};
				`POC_OFF_HV_DIG_EN: nxt_regRdData = {2'h0, hvDigitalEnable_ff};
				`POC_OFF_HV_LEVEL: nxt_regRdData = {2'h0, hvInputLevel};
				`POC_OFF_EVT_STATUS: nxt_regRdData = {5'h00, evtStatus_ff};
				`POC_OFF_EVT_MASK: nxt_regRdData = {5'h00, evtMask_ff};
				default: nxt_regRdData = `POC_RST_BYTE;
			endcase
		end
		nxt_capture = captureToSerialRxRoute_ff ? serialZeroReceive : timerCh1Pin;
		nxt_irq = |(ocFlag & overcurrentIrqEnable_ff) | |(evtStatus_ff & evtMask_ff);
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			portOutputValue_ff <= `POC_RST_PORT;
			portDirection_ff <= `POC_RST_PORT;
			captureToSerialRxRoute_ff <= 1'b0;
			overcurrentMonitorEnable_ff <= `POC_RST_OC;
			reducedDrive_ff <= `POC_RST_PORT;
			overcurrentIrqEnable_ff <= `POC_RST_OC;
			hvAnalogEnable_ff <= `POC_RST_HV;
			hvDirectMode_ff <= `POC_RST_HV;
			hvPullSelect_ff <= `POC_RST_HV;
			hvBufferOverride_ff <= `POC_RST_HV;
			hvDigitalEnable_ff <= `POC_RST_HV;
			evtStatus_ff <= `POC_RST_EVT;
			evtMask_ff <= `POC_RST_EVT;
			regRdData_ff <= `POC_RST_BYTE;
			capture_ff <= 1'b0;
			irq_ff <= 1'b0;
		end
		else
		begin
			portOutputValue_ff <= nxt_portOutputValue;
			portDirection_ff <= nxt_portDirection;
			captureToSerialRxRoute_ff <= nxt_captureToSerialRxRoute;
			overcurrentMonitorEnable_ff <= nxt_overcurrentMonitorEnable;
			reducedDrive_ff <= nxt_reducedDrive;
			overcurrentIrqEnable_ff <= nxt_overcurrentIrqEnable;
			hvAnalogEnable_ff <= nxt_hvAnalogEnable;
			hvDirectMode_ff <= nxt_hvDirectMode;
			hvPullSelect_ff <= nxt_hvPullSelect;
			hvBufferOverride_ff <= nxt_hvBufferOverride;
			hvDigitalEnable_ff <= nxt_hvDigitalEnable;
			evtStatus_ff <= nxt_evtStatus;
			evtMask_ff <= nxt_evtMask;
			regRdData_ff <= nxt_regRdData;
			capture_ff <= nxt_capture;
			irq_ff <= nxt_irq;
		end
	end

	always_comb
	begin
		regRdData = regRdData_ff;
		timerOneCapture1In = capture_ff;
		irq = irq_ff;
		portPinOe = portDirection_ff;
		// Stop mode cannot hold the increased drive, so every pin falls back.
		fullDrive = stopMode ? 3'h0 : ~reducedDrive_ff;
		portPinOut = portOutputValue_ff
			& ~{ocForceLow[1], 1'b0, ocForceLow[0]};
	end

	default clocking poc_cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	sequence oc_clear_write_s;
		regWrStb && regAddr == `POC_OFF_OC_FLAG && regWrData[`POC_PIN_ZERO];
	endsequence

	sequence oc_keep_write_s;
		regWrStb && regAddr == `POC_OFF_OC_FLAG && !regWrData[`POC_PIN_ZERO];
	endsequence

	route_capture_a: assert property (captureToSerialRxRoute_ff
		|=> timerOneCapture1In == $past(serialZeroReceive))
		else $error("capture input does not follow serial receive");
	oc_high_side_a: assert property (ocTrip[1] |-> portDirection_ff[`POC_PIN_TWO]
		&& portOutputValue_ff[`POC_PIN_TWO] && !reducedDrive_ff[`POC_PIN_TWO])
		else $error("trip without full high-side drive");
	oc_enable_a: assert property ($rose(ocFlag[0]) |-> $past(overcurrentMonitorEnable_ff[0])
		&& !$past(stopMode))
		else $error("flag set with monitor unpowered");
	oc_stop_a: assert property (stopMode |-> overcurrentMonitorPower == 2'b00
		&& fullDrive == 3'h0 && ocTrip == 2'b00)
		else $error("monitor or full drive active in stop mode");
	oc_trip_a: assert property (ocTrip[0] |-> !portPinOut[`POC_PIN_ZERO]
		##1 ocFlag[0] && !portPinOut[`POC_PIN_ZERO])
		else $error("trip did not force output low and set flag");
	oc_irq_a: assert property (ocFlag[1] && overcurrentIrqEnable_ff[1] |=> irq)
		else $error("interrupt missing for enabled flag");
	oc_hold_a: assert property (ocFlag[1] && !ocClear[1] |=> ocFlag[1]
		&& !portPinOut[`POC_PIN_TWO])
		else $error("forced output released without a clear");
	oc_clear_a: assert property (ocFlag[0] and oc_clear_write_s |=> !ocFlag[0])
		else $error("write one did not clear the flag");
	oc_keep_a: assert property (ocFlag[0] and oc_keep_write_s |=> ocFlag[0])
		else $error("write zero changed the flag");
	hv_override_a: assert property (!stopMode |-> (hvAnalogEnable_ff & ~hvDirectMode_ff
		& hvBufferOverride_ff & ~hvBufferEnable) == 6'h00)
		else $error("override did not keep the buffer on");
	hv_pull_a: assert property (hvPullUpEn == hvPullSelect_ff
		&& hvPullDownEn == ~hvPullSelect_ff)
		else $error("pull selection mismatch");
endmodule : poc_port_guard

// *** bench/poc_load_model.sv ***
`timescale 1ns/1ps
module poc_load_model (
	input wire logic clk,
	input wire logic [1:0] shortCmd,
	input wire logic [5:0] extDown,
	input wire logic [5:0] extUp,
	input wire logic [2:0] portPinOut,
	input wire logic [2:0] portPinOe,
	input wire logic [2:0] fullDrive,
	input wire logic [5:0] hvPullUpEn,
	output logic [1:0] overcurrentDetect,
	output logic [2:0] portPinIn,
	output logic [5:0] hvPadLevel
);
	// A short only draws excess current while the pin sources high at full drive.
	// Sampling it on the clock keeps the comparator out of a loop with the forced output.
	always_ff @(posedge clk)
	begin
		overcurrentDetect[0] <= shortCmd[0] & portPinOe[0] & portPinOut[0] & fullDrive[0];
		overcurrentDetect[1] <= shortCmd[1] & portPinOe[2] & portPinOut[2] & fullDrive[2];
	end
	// Loads to ground pull an undriven pin low.
	assign portPinIn = portPinOut & portPinOe;
	// A strong external pull wins over the weak internal one; an open pin follows the internal.
	assign hvPadLevel = ~extDown & (extUp | hvPullUpEn);
endmodule : poc_load_model

// *** bench/testbench.sv ***
`timescale 1ns/1ps
module testbench;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [3:0] regAddr = 4'h0;
	logic [7:0] regWrData = 8'h00;
	logic regWrStb = 1'b0;
	logic regRdStb = 1'b0;
	logic [7:0] regRdData;
	logic stopMode = 1'b0;
	logic [2:0] portPinIn, portPinOut, portPinOe, fullDrive;
	logic [1:0] overcurrentDetect, overcurrentMonitorPower;
	logic [1:0] shortCmd = 2'h0;
	logic timerCh1Pin = 1'b0;
	logic serialZeroReceive = 1'b1;
	logic timerOneCapture1In;
	logic [5:0] hvPadLevel, hvBufferEnable, hvPullUpEn, hvPullDownEn;
	logic [5:0] extDown = 6'h00;
	logic [5:0] extUp = 6'h00;
	logic irq;
	logic [7:0] rdv, ps, dn, up;
	int num_errors = 0;
	int n_tests = 0;
	logic [3:0] rwAddr [11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hE};
	logic [7:0] rwMask [11] = '{8'h07, 8'h07, 8'h80, 8'h05, 8'h07, 8'h05, 8'h3F, 8'h3F, 8'h3F,
		8'h3F, 8'h07};

	always #12.5 clk = ~clk;

	poc_port_guard poc_port_guard_inst (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr),
		.regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
		.stopMode(stopMode), .portPinIn(portPinIn), .portPinOut(portPinOut),
		.portPinOe(portPinOe), .fullDrive(fullDrive), .overcurrentDetect(overcurrentDetect),
		.overcurrentMonitorPower(overcurrentMonitorPower), .timerCh1Pin(timerCh1Pin),
		.serialZeroReceive(serialZeroReceive), .timerOneCapture1In(timerOneCapture1In),
		.hvPadLevel(hvPadLevel), .hvBufferEnable(hvBufferEnable), .hvPullUpEn(hvPullUpEn),
		.hvPullDownEn(hvPullDownEn), .irq(irq));

	poc_load_model poc_load_model_inst (.clk(clk), .shortCmd(shortCmd), .extDown(extDown),
		.extUp(extUp), .portPinOut(portPinOut), .portPinOe(portPinOe), .fullDrive(fullDrive),
		.hvPullUpEn(hvPullUpEn), .overcurrentDetect(overcurrentDetect), .portPinIn(portPinIn),
		.hvPadLevel(hvPadLevel));

	function automatic logic [7:0] hvExpect(input logic [7:0] d, input logic [7:0] u,
		input logic [7:0] p);
		return 8'h3F & ~d & (u | p);
	endfunction : hvExpect

	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regWrData <= d;
		regWrStb <= 1'b1;
		@(posedge clk);
		regWrStb <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regRdStb <= 1'b1;
		@(posedge clk);
		regRdStb <= 1'b0;
		#1 d = regRdData;
	endtask : rd

	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : settle

	// Trips one monitored pin, then walks the flag through hold, clear and refusal cases.
	task automatic ocCase(input int p, input int i);
		logic [7:0] pm;
		pm = 8'h01 << p;
		wr(4'h0, pm);
		wr(4'h1, pm);
		wr(4'h4, 8'h00);
		wr(4'h3, pm);
		wr(4'h6, pm);
		wr(4'hE, 8'h00);
		rd(4'hD, rdv);
		settle(2);
		chk("pinHigh", 8'(portPinOut[p]), 8'h01);
		chk("pinOe", 8'(portPinOe), pm);
		chk("monPower", 8'(overcurrentMonitorPower[i]), 8'h01);
		@(posedge clk);
		shortCmd[i] <= 1'b1;
		for (int k = 0; k < 5; k++)
		begin
			settle(1);
			if (overcurrentDetect[i] === 1'b1)
				break;
		end
		chk("forcedLow", 8'(portPinOut[p]), 8'h00);
		@(posedge clk);
		shortCmd[i] <= 1'b0;
		settle(2);
		chk("irqOn", 8'(irq), 8'h01);
		rd(4'h5, rdv);
		chk("flagSet", rdv, pm);
		rd(4'hD, rdv);
		chk("tripEvent", rdv, 8'h01 << i);
		rd(4'hD, rdv);
		chk("evtCleared", rdv, 8'h00);
		chk("stillLow", 8'(portPinOut[p]), 8'h00);
		wr(4'h5, 8'h00);
		rd(4'h5, rdv);
		chk("zeroKeeps", rdv, pm);
		wr(4'h6, 8'h00);
		settle(2);
		chk("irqMasked", 8'(irq), 8'h00);
		wr(4'h5, pm);
		settle(1);
		chk("released", 8'(portPinOut[p]), 8'h01);
		rd(4'h5, rdv);
		chk("flagClear", rdv, 8'h00);
		wr(4'h3, 8'h00);
		@(posedge clk);
		shortCmd[i] <= 1'b1;
		settle(4);
		chk("monOff", 8'(overcurrentMonitorPower[i]), 8'h00);
		chk("noTripOff", 8'(portPinOut[p]), 8'h01);
		shortCmd[i] <= 1'b0;
		wr(4'h3, pm);
		wr(4'h4, pm);
		settle(1);
		chk("reduced", 8'(fullDrive[p]), 8'h00);
		wr(4'h4, 8'h00);
		wr(4'h0, 8'h00);
		stopMode <= 1'b1;
		settle(2);
		chk("stopMon", 8'(overcurrentMonitorPower[i]), 8'h00);
		chk("stopDrive", 8'(fullDrive[p]), 8'h00);
		rd(4'h5, rdv);
		chk("stopNoFlag", rdv, 8'h00);
		stopMode <= 1'b0;
	endtask : ocCase

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : final_report

	initial
	begin
		repeat (20000) @(posedge clk);
		num_errors++;
		final_report();
	end

	initial
	begin
		void'($urandom(32'he04a));
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		settle(1);
		chk("rstDrive", 8'(fullDrive), 8'h07);
		chk("rstPullDn", 8'(hvPullDownEn), 8'h3F);
		chk("rstIrq", 8'(irq), 8'h00);
		for (int a = 0; a < 16; a++)
		begin
			rd(4'(a), rdv);
			chk("rstReg", rdv, 8'h00);
		end
		wr(4'hF, 8'hFF);
		rd(4'hF, rdv);
		chk("unmapped", rdv, 8'h00);
		for (int k = 0; k < 11; k++)
		begin
			rdv = 8'($urandom);
			wr(rwAddr[k], rdv);
			rd(rwAddr[k], dn);
			chk("regRw", dn, rdv & rwMask[k]);
		end
		settle(1);
		chk("rdIdle", regRdData, 8'h00);
		wr(4'h2, 8'h80);
		for (int k = 0; k < 9; k++)
		begin
			@(posedge clk);
			serialZeroReceive <= (k < 8) ? 1'($urandom) : serialZeroReceive;
			timerCh1Pin <= ~serialZeroReceive;
			if (k == 8)
				regWrStb <= 1'b0;
			settle(1);
			chk("capture", 8'(timerOneCapture1In), 8'(serialZeroReceive));
		end
		wr(4'h2, 8'h00);
		settle(2);
		chk("captureTimer", 8'(timerOneCapture1In), 8'(timerCh1Pin));
		ocCase(0, 0);
		ocCase(2, 1);
		for (int k = 0; k < 4; k++)
		begin
			ps = 8'h3F & 8'($urandom);
			dn = 8'h3F & 8'($urandom);
			up = 8'h3F & 8'($urandom);
			extDown <= dn[5:0];
			extUp <= up[5:0];
			wr(4'h7, 8'h3F);
			wr(4'h8, 8'h00);
			wr(4'h9, ps);
			wr(4'hA, 8'h3F);
			wr(4'hB, 8'h3F & 8'($urandom));
			settle(3);
			chk("bufForced", 8'(hvBufferEnable), 8'h3F);
			chk("pullUp", 8'(hvPullUpEn), ps);
			chk("pullDn", 8'(hvPullDownEn), 8'h3F & ~ps);
			rd(4'hC, rdv);
			chk("openCheck", rdv, hvExpect(dn, up, ps));
			wr(4'h8, 8'h3F);
			settle(1);
			chk("bufDirect", 8'(hvBufferEnable), 8'h00);
			wr(4'h8, 8'h00);
			wr(4'hA, 8'h00);
			settle(1);
			chk("bufAuto", 8'(hvBufferEnable), 8'h00);
		end
		extDown <= 6'h00;
		extUp <= 6'h00;
		wr(4'h7, 8'h00);
		wr(4'hB, 8'h3F);
		wr(4'h9, 8'h00);
		wr(4'hE, 8'h04);
		settle(3);
		rd(4'hD, rdv);
		wr(4'h9, 8'h3F);
		settle(3);
		chk("hvIrq", 8'(irq), 8'h01);
		rd(4'hD, rdv);
		chk("hvEvent", rdv, 8'h04);
		settle(2);
		chk("hvIrqOff", 8'(irq), 8'h00);
		final_report();
	end
endmodule : testbench
